/* rtl/lgtb_pkg.sv */
// Package for the logic gate and timer block library.
// Assumes a single 25 MHz clock feeding every block.
package lgtb_pkg;

    // =========================================================
    // Clock and time base
    localparam int unsigned CLK_HZ        = 25_000_000;
    // Setting is in hundredths of a unit: 1 .. 9999
    localparam int unsigned TICK_PER_SEC  = 100;
    localparam int unsigned SEC_PER_MIN   = 60;
    localparam int unsigned MIN_PER_HOUR  = 60;
    localparam int unsigned CYC_PER_TICK  = CLK_HZ / TICK_PER_SEC;
    localparam int unsigned SET_MIN       = 1;
    localparam int unsigned SET_MAX       = 9999;
    localparam int unsigned SET_W         = 14;
    localparam int unsigned PRE_W         = 18;
    localparam int unsigned SUB_W         = 12;

    // =========================================================
    // Time unit selection
    typedef enum logic [1:0] {
        LGTB_UNIT_SEC  = 2'h0,
        LGTB_UNIT_MIN  = 2'h1,
        LGTB_UNIT_HOUR = 2'h2
    } lgtb_unit_t;

    localparam logic [SET_W-1:0] SET_MIN_V = SET_W'(SET_MIN);
    localparam logic [SET_W-1:0] SET_MAX_V = SET_W'(SET_MAX);

endpackage

/* rtl/lgtb_timebase.sv */
// Time base: one-cycle pulses at 1/100 s, 1/100 min and 1/100 h.
// Assumes ref_clk at the rate given in the package.
`timescale 1ns/1ps
`default_nettype none
module lgtb_timebase
    import lgtb_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Tick pulses
    output logic      tick_sec,
    output logic      tick_min,
    output logic      tick_hour
);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_TICK - 1);
    localparam logic [SUB_W-1:0] MIN_LAST = SUB_W'(SEC_PER_MIN - 1);
    localparam logic [SUB_W-1:0] HR_LAST  = SUB_W'(MIN_PER_HOUR - 1);

    logic [PRE_W-1:0] pre_cnt;
    logic [SUB_W-1:0] min_cnt;
    logic [SUB_W-1:0] hr_cnt;

    // =========================================================
    // Prescaler to hundredths of a second
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pre_cnt  <= '0;
            tick_sec <= 1'b0;
        end else begin
            tick_sec <= (pre_cnt == PRE_LAST);
            pre_cnt  <= (pre_cnt == PRE_LAST) ? '0 : pre_cnt + 1'b1;
        end
    end

    // =========================================================
    // Cascaded dividers for minutes and hours
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            min_cnt  <= '0;
            tick_min <= 1'b0;
        end else begin
            tick_min <= tick_sec && (min_cnt == MIN_LAST);
            if (tick_sec)
                min_cnt <= (min_cnt == MIN_LAST) ? '0 : min_cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hr_cnt    <= '0;
            tick_hour <= 1'b0;
        end else begin
            tick_hour <= tick_min && (hr_cnt == HR_LAST);
            if (tick_min)
                hr_cnt <= (hr_cnt == HR_LAST) ? '0 : hr_cnt + 1'b1;
        end
    end
endmodule
`default_nettype wire

/* rtl/lgtb_blocks.sv */
// Gate and timer function blocks sharing one clock and power-up reset.
// Assumes block inputs are already synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module lgtb_blocks
    import lgtb_pkg::*;
(
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // Gate inputs
    input  wire logic             gate_in_a,
    input  wire logic             gate_in_b,
    input  wire logic             gate_in_c,
    // Gate outputs
    output logic                  or_out,
    output logic                  not_out,
    output logic                  nand_out,
    output logic                  nor_out,
    output logic                  xor_out,
    // On-delay timer
    input  wire logic             on_delay_trigger_in,
    input  wire logic [SET_W-1:0] on_delay_setting,
    input  wire logic [1:0]       on_delay_unit,
    output logic                  on_delay_out,
    // Off-delay timer
    input  wire logic             off_delay_trigger_in,
    input  wire logic             off_delay_reset,
    input  wire logic [SET_W-1:0] off_delay_setting,
    input  wire logic [1:0]       off_delay_unit,
    output logic                  off_delay_out,
    // Toggle relay
    input  wire logic             toggle_trigger_in,
    input  wire logic             toggle_reset,
    output logic                  toggle_relay
);
    logic tick_sec;
    logic tick_min;
    logic tick_hour;

    // =========================================================
    // Shared time base
    lgtb_timebase i_lgtb_timebase (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .tick_sec  (tick_sec),
        .tick_min  (tick_min),
        .tick_hour (tick_hour)
    );

    // Pick the tick for a unit code; unknown codes fall back to seconds
    function automatic logic unit_tick(input logic [1:0] unit,
                                       input logic ts,
                                       input logic tm,
                                       input logic th);
        logic t;
        t = ts;
        case (unit)
            LGTB_UNIT_SEC:  t = ts;
            LGTB_UNIT_MIN:  t = tm;
            LGTB_UNIT_HOUR: t = th;
            default:        t = ts;
        endcase
        return t;
    endfunction

    // Clamp a setting into the legal span
    function automatic logic [SET_W-1:0] clamp_set(input logic [SET_W-1:0] v);
        logic [SET_W-1:0] c;
        c = v;
        if (v < SET_MIN_V)
            c = SET_MIN_V;
        else if (v > SET_MAX_V)
            c = SET_MAX_V;
        return c;
    endfunction

    // =========================================================
    // Combinational gates, registered for clean data outputs
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            or_out   <= 1'b0;
            not_out  <= 1'b1;
            nand_out <= 1'b1;
            nor_out  <= 1'b1;
            xor_out  <= 1'b0;
        end else begin
            or_out   <= gate_in_a | gate_in_b | gate_in_c;
            not_out  <= ~gate_in_a;
            nand_out <= ~(gate_in_a & gate_in_b & gate_in_c);
            nor_out  <= ~(gate_in_a | gate_in_b | gate_in_c);
            xor_out  <= gate_in_a ^ gate_in_b;
        end
    end

    // =========================================================
    // Previous-cycle copies for edge detection
    logic on_trig_q;
    logic off_trig_q;
    logic tog_trig_q;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            on_trig_q  <= 1'b0;
            off_trig_q <= 1'b0;
            tog_trig_q <= 1'b0;
        end else begin
            on_trig_q  <= on_delay_trigger_in;
            off_trig_q <= off_delay_trigger_in;
            tog_trig_q <= toggle_trigger_in;
        end
    end

    logic on_rise;
    logic off_fall;
    logic tog_rise;
    assign on_rise  = on_delay_trigger_in & ~on_trig_q;
    assign off_fall = ~off_delay_trigger_in & off_trig_q;
    assign tog_rise = toggle_trigger_in & ~tog_trig_q;

    // =========================================================
    // On-delay timer
    // Count starts at the rise, so the first unit tick may come early
    // by up to one hundredth of a unit; accuracy matches the setting step.
    logic [SET_W-1:0] on_cnt;
    logic             on_run;
    logic             on_tick;
    assign on_tick = unit_tick(on_delay_unit, tick_sec, tick_min, tick_hour);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            on_cnt       <= '0;
            on_run       <= 1'b0;
            on_delay_out <= 1'b0;
        end else if (!on_delay_trigger_in) begin
            on_cnt       <= '0;
            on_run       <= 1'b0;
            on_delay_out <= 1'b0;
        end else if (on_rise) begin
            on_cnt       <= '0;
            on_run       <= 1'b1;
            on_delay_out <= 1'b0;
        end else if (on_run && on_tick) begin
            if (on_cnt + 1'b1 >= clamp_set(on_delay_setting)) begin
                on_run       <= 1'b0;
                on_delay_out <= 1'b1;
                on_cnt       <= '0;
            end else begin
                on_cnt <= on_cnt + 1'b1;
            end
        end
    end

    // =========================================================
    // Off-delay timer with reset
    logic [SET_W-1:0] off_cnt;
    logic             off_run;
    logic             off_tick;
    assign off_tick = unit_tick(off_delay_unit, tick_sec, tick_min,
                                tick_hour);

    always_ff @(posedge ref_clk) begin
        if (sys_rst || off_delay_reset) begin
            off_cnt       <= '0;
            off_run       <= 1'b0;
            off_delay_out <= 1'b0;
        end else if (off_delay_trigger_in) begin
            off_cnt       <= '0;
            off_run       <= 1'b0;
            off_delay_out <= 1'b1;
        end else if (off_fall) begin
            off_cnt       <= '0;
            off_run       <= 1'b1;
            off_delay_out <= 1'b1;
        end else if (off_run && off_tick) begin
            if (off_cnt + 1'b1 >= clamp_set(off_delay_setting)) begin
                off_run       <= 1'b0;
                off_cnt       <= '0;
                off_delay_out <= 1'b0;
            end else begin
                off_cnt <= off_cnt + 1'b1;
            end
        end
    end

    // =========================================================
    // Toggle relay
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            toggle_relay <= 1'b0;
        end else if (toggle_reset) begin
            toggle_relay <= 1'b0;
        end else if (tog_rise) begin
            toggle_relay <= ~toggle_relay;
        end
    end
endmodule
`default_nettype wire

/* verif/lgtb_blocks_asserts.sv */
// Port-level checks for the gate and timer blocks.
// Assumes it is bound onto lgtb_blocks, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module lgtb_blocks_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Gates
    input wire logic gate_in_a,
    input wire logic gate_in_b,
    input wire logic gate_in_c,
    input wire logic or_out,
    input wire logic not_out,
    input wire logic nand_out,
    input wire logic nor_out,
    input wire logic xor_out,
    // Timers and toggle
    input wire logic on_delay_trigger_in,
    input wire logic on_delay_out,
    input wire logic off_delay_trigger_in,
    input wire logic off_delay_reset,
    input wire logic off_delay_out,
    input wire logic toggle_trigger_in,
    input wire logic toggle_reset,
    input wire logic toggle_relay
);
    // ==========================================================
    // Helpers
    logic any_in;
    logic all_in;
    logic dif_in;
    assign any_in = gate_in_a | gate_in_b | gate_in_c;
    assign all_in = gate_in_a & gate_in_b & gate_in_c;
    assign dif_in = gate_in_a ^ gate_in_b;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // Gates: skip the first edge after reset release
    AST_OR: assert property (!$past(sys_rst) |-> or_out == $past(any_in))
        else $error("or output wrong");
    AST_NOT: assert property (!$past(sys_rst) |-> not_out != $past(gate_in_a))
        else $error("not output wrong");
    AST_NAND: assert property (!$past(sys_rst) |-> nand_out == !$past(all_in))
        else $error("nand output wrong");
    AST_NOR: assert property (!$past(sys_rst) |-> nor_out != $past(any_in))
        else $error("nor output wrong");
    AST_XOR: assert property (!$past(sys_rst) |-> xor_out == $past(dif_in))
        else $error("xor output wrong");
    // ==========================================================
    // Timers and toggle
    AST_ON_LOW: assert property (!on_delay_trigger_in |=> !on_delay_out)
        else $error("on-delay output high with trigger low");
    AST_OFF_HIGH: assert property (off_delay_trigger_in && !off_delay_reset |=> off_delay_out)
        else $error("off-delay output not high");
    AST_OFF_RST: assert property (off_delay_reset |=> !off_delay_out)
        else $error("off-delay reset ignored");
    AST_TGL_FLIP: assert property ($rose(toggle_trigger_in) && !toggle_reset && !$past(sys_rst) |=> toggle_relay != $past(toggle_relay))
        else $error("toggle missed an edge");
    AST_TGL_HOLD: assert property (!$rose(toggle_trigger_in) && !toggle_reset && !$past(sys_rst) |=> $stable(toggle_relay))
        else $error("toggle changed without edge");
    AST_TGL_RST: assert property (toggle_reset |=> !toggle_relay)
        else $error("toggle reset ignored");
    AST_ON_EDGE: assert property
        ($rose(on_delay_trigger_in) |=> !on_delay_out)
        else $error("on-delay output rose with no delay");
    AST_OFF_FALL: assert property
        ($fell(off_delay_trigger_in) && !off_delay_reset && !$past(sys_rst)
            |=> off_delay_out)
        else $error("off-delay output dropped at trigger fall");
endmodule
bind lgtb_blocks lgtb_blocks_chk i_lgtb_blocks_chk (.ref_clk, .sys_rst,
    .gate_in_a, .gate_in_b, .gate_in_c, .or_out, .not_out, .nand_out,
    .nor_out, .xor_out, .on_delay_trigger_in, .on_delay_out,
    .off_delay_trigger_in, .off_delay_reset, .off_delay_out,
    .toggle_trigger_in, .toggle_reset, .toggle_relay);
`default_nettype wire

/* verif/lgtb_blocks_test.sv */
// Random self-checking bench for the gate and timer blocks.
// Assumes the 10 ms tick: timer expiry lies beyond this run's length.
`timescale 1ns/1ps
`default_nettype none
module lgtb_blocks_test;
    import lgtb_pkg::*;
    typedef struct packed {
        logic [4:0] gates;
        logic tg, off_v;
    } lgtb_note_t;
    logic ref_clk, sys_rst, gate_in_a, gate_in_b, gate_in_c;
    logic or_out, not_out, nand_out, nor_out, xor_out;
    logic on_delay_trigger_in, on_delay_out, off_delay_trigger_in;
    logic off_delay_reset, off_delay_out, toggle_trigger_in;
    logic toggle_reset, toggle_relay;
    logic [SET_W-1:0] on_delay_setting, off_delay_setting;
    logic [1:0] on_delay_unit, off_delay_unit;
    lgtb_note_t notes[$];
    lgtb_note_t n, m;
    logic [31:0] seed = 32'h0000C786;
    logic tg = 1'b0, t_prev = 1'b0, o_prev = 1'b0, offv = 1'b0;
    int miscompares = 0, n_compared = 0, cycles = 0;
    lgtb_blocks i_lgtb_blocks (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .gate_in_a(gate_in_a), .gate_in_b(gate_in_b), .gate_in_c(gate_in_c),
        .or_out(or_out), .not_out(not_out), .nand_out(nand_out),
        .nor_out(nor_out), .xor_out(xor_out),
        .on_delay_trigger_in(on_delay_trigger_in),
        .on_delay_setting(on_delay_setting), .on_delay_unit(on_delay_unit),
        .on_delay_out(on_delay_out),
        .off_delay_trigger_in(off_delay_trigger_in),
        .off_delay_reset(off_delay_reset),
        .off_delay_setting(off_delay_setting),
        .off_delay_unit(off_delay_unit), .off_delay_out(off_delay_out),
        .toggle_trigger_in(toggle_trigger_in), .toggle_reset(toggle_reset),
        .toggle_relay(toggle_relay));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [4:0] seen, input logic [4:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %b want %b", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // Clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end
    // ==========================================================
    // Driver: note what the last edge sampled, then drive anew
    initial begin
        {sys_rst, gate_in_a, gate_in_b, gate_in_c} = 4'h8;
        {on_delay_trigger_in, off_delay_trigger_in, off_delay_reset} = 3'h0;
        {toggle_trigger_in, toggle_reset} = 2'h0;
        {on_delay_setting, off_delay_setting} = 28'h0;
        {on_delay_unit, off_delay_unit} = 4'h0;
        for (int k = 0; k < 3000; k++) begin
            @(posedge ref_clk);
            m.gates = sys_rst ? 5'h0E : {gate_in_a | gate_in_b | gate_in_c,
                !gate_in_a, !(gate_in_a & gate_in_b & gate_in_c),
                !(gate_in_a | gate_in_b | gate_in_c), gate_in_a ^ gate_in_b};
            if (sys_rst || toggle_reset) begin
                tg = 1'b0;
            end else if (toggle_trigger_in && !t_prev) begin
                tg = !tg;
            end
            // No expiry within this run: a fall keeps the output high
            if (sys_rst || off_delay_reset) begin
                offv = 1'b0;
            end else if (off_delay_trigger_in || o_prev) begin
                offv = 1'b1;
            end
            t_prev = toggle_trigger_in;
            o_prev = off_delay_trigger_in;
            m.tg = tg;
            m.off_v = offv;
            notes.push_back(m);
            #1;
            seed = xs(seed);
            {gate_in_a, gate_in_b, gate_in_c} = seed[2:0];
            on_delay_trigger_in = |seed[5:3];
            off_delay_trigger_in = seed[6];
            off_delay_reset = &seed[9:7];
            toggle_trigger_in = seed[10];
            toggle_reset = &seed[12:11];
            on_delay_setting = seed[25:12];
            on_delay_unit = seed[27:26];
            off_delay_setting = seed[31:18];
            off_delay_unit = seed[17:16];
            sys_rst = (k < 7) || (k >= 1501 && k <= 1503);
            // Quiet toggle and off-delay triggers around resets: edge history stays defined
            if (k < 8 || (k >= 1500 && k <= 1504)) begin
                {toggle_trigger_in, off_delay_trigger_in} = 2'h0;
            end
        end
        repeat (3) @(posedge ref_clk);
        summarize();
    end
    // ==========================================================
    // Monitor: settled outputs against the oldest note
    initial forever begin
        @(posedge ref_clk);
        #2;
        if (notes.size() > 0) begin
            n = notes.pop_front();
            check({or_out, not_out, nand_out, nor_out, xor_out}, n.gates);
            check(5'(toggle_relay), 5'(n.tg));
            check(5'(on_delay_out), 5'h0);
            check(5'(off_delay_out), 5'(n.off_v));
        end
    end
endmodule
`default_nettype wire
